// >>> hdl/calib_chan_if.sv
// Purpose: Carries one channel's settings and counts between the stages.
// Assumes: One instance per channel, all on pclk.
// Notes: The control side drives settings, the stages produce counts.
interface calib_chan_if;
  logic        range_020;
  logic        fmt_unsigned;
  logic        enable;
  logic [15:0] offset;
  logic [15:0] max_count;
  logic [15:0] raw_count;
  logic        raw_valid;
  logic [15:0] result;
  logic [7:0]  status;
  logic        result_valid;
  modport conv (input range_020, fmt_unsigned, output raw_count, raw_valid);
  modport cal (input fmt_unsigned, enable, offset, max_count, raw_count, raw_valid,
               output result, status, result_valid);
endinterface

// >>> hdl/calib_pkg.sv
// Purpose: Shared constants of the four-channel current input calibration block.
// Assumes: APB byte addresses, 32-bit data, one register per aligned word.
// Notes: Input current arrives in microamperes, one 16-bit word per channel.
package calib_pkg;
  localparam int NUM_CH = 4;
  // Register byte addresses.
  localparam logic [7:0] ADDR_CONFIG    = 8'h00;
  localparam logic [7:0] ADDR_REQUEST   = 8'h04;
  localparam logic [7:0] ADDR_REQ_DATA  = 8'h08;
  localparam logic [7:0] ADDR_RESPONSE  = 8'h0c;
  localparam logic [7:0] ADDR_RESP_DATA = 8'h10;
  localparam logic [7:0] ADDR_RESULT    = 8'h20;
  // Field positions.
  localparam int CFG_RANGE_LSB  = 0;
  localparam int CFG_FMT_LSB    = 4;
  localparam int CFG_EN_LSB     = 8;
  localparam int REQ_IDXLO_LSB  = 0;
  localparam int REQ_IDXHI_LSB  = 8;
  localparam int REQ_SUB_LSB    = 16;
  localparam int REQ_LEN_LSB    = 24;
  localparam int REQ_WR_BIT     = 28;
  localparam int RESP_DONE_BIT  = 0;
  localparam int RESP_ERR_BIT   = 1;
  localparam int RES_STATUS_LSB = 16;
  localparam int STAT_LO_BIT    = 0;
  localparam int STAT_HI_BIT    = 1;
  // Reset values.
  localparam logic [3:0]  CFG_RANGE_RESET = 4'h0;
  localparam logic [3:0]  CFG_FMT_RESET   = 4'h0;
  localparam logic [3:0]  CFG_EN_RESET    = 4'hf;
  localparam logic [15:0] OFF_RESET       = 16'h0000;
  localparam logic [7:0]  AVG_RESET       = 8'h01;
  // Parameter access coding.
  localparam logic [7:0] IDX_HI_PARAM = 8'h24;
  localparam logic [7:0] IDX_OFFSET   = 8'h00;
  localparam logic [7:0] IDX_MAXCNT   = 8'h01;
  localparam logic [7:0] IDX_AVERAGE  = 8'h02;
  localparam logic [3:0] LEN_WORD     = 4'h2;
  localparam logic [3:0] LEN_BYTE     = 4'h1;
  localparam logic [7:0] SUB_FIRST    = 8'h01;
  localparam logic [7:0] SUB_LAST     = 8'h04;
  // Accepted limits.
  localparam logic [15:0] OFF_S_MIN = 16'hfd01;
  localparam logic [15:0] OFF_S_MAX = 16'h02ff;
  localparam logic [15:0] OFF_U_MAX = 16'h05ff;
  localparam logic [15:0] MAX_S_MIN = 16'h7a01;
  localparam logic [15:0] MAX_S_MAX = 16'h7fff;
  localparam logic [15:0] MAX_U_MIN = 16'hf401;
  localparam logic [7:0]  AVG_MIN   = 8'h01;
  localparam logic [7:0]  AVG_MAX   = 8'h50;
  // Full-scale counts and conversion.
  localparam logic [15:0] FS_S        = 16'h7d00;
  localparam logic [15:0] FS_U        = 16'hfa00;
  localparam logic [15:0] CUR_20MA_UA = 16'h4e20;
  localparam logic signed [23:0] LIVE_ZERO_UA = 24'sh00_0fa0;
  localparam logic signed [23:0] DIV_FIVE     = 24'sh00_0005;
  localparam int LZ_SHIFT_S = 1;
  localparam int LZ_SHIFT_U = 2;
  localparam int FZ_SHIFT_S = 3;
  localparam int FZ_SHIFT_U = 4;
  localparam logic signed [23:0] SAT_S_HI = 24'sh00_7fff;
  localparam logic signed [23:0] SAT_S_LO = 24'shff_8000;
  localparam logic signed [23:0] SAT_U_HI = 24'sh00_ffff;
  localparam logic signed [23:0] SAT_U_LO = 24'sh00_0000;
endpackage

// >>> hdl/count_calibrator.sv
// Purpose: Applies one channel's offset and full-scale correction.
// Assumes: Full-scale count always exceeds the offset, so the divisor is positive.
// Notes: A disabled channel reports zero result and zero status.
module count_calibrator (
  input  wire logic pclk,
  input  wire logic presetn,
  calib_chan_if.cal ch
);
  logic signed [23:0] raw_ext;
  logic signed [23:0] off_ext;
  logic signed [23:0] max_ext;
  logic signed [23:0] fs_ext;
  logic signed [39:0] num;
  logic signed [39:0] den;
  logic signed [39:0] quo;
  logic signed [39:0] hi_lim;
  logic signed [39:0] lo_lim;
  logic signed [39:0] sat;
  logic               clip_hi;
  logic               clip_lo;
  logic [7:0]         status_next;

  // Raw count and offset are sign-extended only in the signed format; full-scale counts never are.
  assign raw_ext = ch.fmt_unsigned ? {8'h00, ch.raw_count} : {{8{ch.raw_count[15]}}, ch.raw_count};
  assign off_ext = ch.fmt_unsigned ? {8'h00, ch.offset} : {{8{ch.offset[15]}}, ch.offset};
  assign max_ext = {8'h00, ch.max_count};
  assign fs_ext  = {8'h00, (ch.fmt_unsigned ? calib_pkg::FS_U : calib_pkg::FS_S)};

  // Linear map: offset goes to zero, full-scale count to the nominal full scale.
  assign num = 40'(raw_ext - off_ext) * 40'(fs_ext);
  assign den = 40'(max_ext - off_ext);
  assign quo = num / den;

  // Saturate instead of wrapping.
  assign hi_lim  = ch.fmt_unsigned ? 40'(calib_pkg::SAT_U_HI) : 40'(calib_pkg::SAT_S_HI);
  assign lo_lim  = ch.fmt_unsigned ? 40'(calib_pkg::SAT_U_LO) : 40'(calib_pkg::SAT_S_LO);
  assign clip_hi = quo > hi_lim;
  assign clip_lo = quo < lo_lim;
  assign sat     = clip_hi ? hi_lim : clip_lo ? lo_lim : quo;
  assign status_next = (8'(clip_hi) << calib_pkg::STAT_HI_BIT)
                     | (8'(clip_lo) << calib_pkg::STAT_LO_BIT);

  // Result and status registers, forced to zero when the channel is off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch.result       <= 16'h0000;
      ch.status       <= 8'h00;
      ch.result_valid <= 1'b0;
    end else begin
      ch.result       <= ch.enable ? sat[15:0] : 16'h0000;
      ch.status       <= ch.enable ? status_next : 8'h00;
      ch.result_valid <= ch.raw_valid;
    end
  end

  AST_DIS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    !ch.enable |=> ch.result == 16'h0000 && ch.status == 8'h00)
    else $error("Disabled channel reports a nonzero value.");
  AST_AT_OFFSET: assert property (@(posedge pclk) disable iff (!presetn)
    ch.enable && raw_ext == off_ext |=> ch.result == 16'h0000)
    else $error("Raw count at offset does not map to zero.");
  AST_AT_MAX: assert property (@(posedge pclk) disable iff (!presetn)
    ch.enable && raw_ext == max_ext |=> ch.result == 16'($past(fs_ext)))
    else $error("Raw count at full-scale count does not map to full scale.");
  AST_CLIP_HI: assert property (@(posedge pclk) disable iff (!presetn)
    ch.enable && clip_hi |=> ch.result == 16'($past(hi_lim)) && ch.status[calib_pkg::STAT_HI_BIT])
    else $error("Overrange count is not saturated.");
endmodule // count_calibrator

// >>> hdl/count_converter.sv
// Purpose: Turns one channel's input current into an uncorrected count.
// Assumes: Input current in microamperes, same clock as the block.
// Notes: The raw count is clamped to the active format before calibration.
module count_converter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] input_current,
  input  wire logic        sample_valid,
  calib_chan_if.conv       ch
);
  logic signed [23:0] cur_ext;
  logic signed [23:0] span_val;
  logic signed [23:0] lz_val;
  logic signed [23:0] fz_val;
  logic signed [23:0] scaled;
  logic signed [23:0] hi_lim;
  logic signed [23:0] lo_lim;
  logic signed [23:0] clamped;

  // Shift to the live-zero origin unless range_020 is set, then scale by the span and format gain.
  assign cur_ext  = {8'h00, input_current};
  assign span_val = ch.range_020 ? cur_ext : cur_ext - calib_pkg::LIVE_ZERO_UA;
  assign lz_val   = span_val <<< (ch.fmt_unsigned ? calib_pkg::LZ_SHIFT_U
                                                  : calib_pkg::LZ_SHIFT_S);
  assign fz_val   = (span_val <<< (ch.fmt_unsigned ? calib_pkg::FZ_SHIFT_U
                                                   : calib_pkg::FZ_SHIFT_S))
                    / calib_pkg::DIV_FIVE;
  assign scaled   = ch.range_020 ? fz_val : lz_val;

  // Clamp to the representable range of the active format.
  assign hi_lim  = ch.fmt_unsigned ? calib_pkg::SAT_U_HI : calib_pkg::SAT_S_HI;
  assign lo_lim  = ch.fmt_unsigned ? calib_pkg::SAT_U_LO : calib_pkg::SAT_S_LO;
  assign clamped = (scaled > hi_lim) ? hi_lim : (scaled < lo_lim) ? lo_lim : scaled;

  // The count register follows the input every cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch.raw_count <= 16'h0000;
      ch.raw_valid <= 1'b0;
    end else begin
      ch.raw_count <= clamped[15:0];
      ch.raw_valid <= sample_valid;
    end
  end

  AST_LZ_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    !ch.range_020 && input_current == calib_pkg::LIVE_ZERO_UA[15:0] |=> ch.raw_count == 16'h0000)
    else $error("Live-zero span does not give zero at 4 mA.");
  AST_LZ_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    !ch.range_020 && input_current == calib_pkg::CUR_20MA_UA |=>
      ch.raw_count == ($past(ch.fmt_unsigned) ? calib_pkg::FS_U : calib_pkg::FS_S))
    else $error("Live-zero span full-scale count is wrong.");
  AST_FZ_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    ch.range_020 && input_current == calib_pkg::CUR_20MA_UA |=>
      ch.raw_count == ($past(ch.fmt_unsigned) ? calib_pkg::FS_U : calib_pkg::FS_S))
    else $error("Zero-based span full-scale count is wrong.");
endmodule // count_converter

// >>> hdl/current_input_calibration.sv
// Purpose: Four-channel current conversion and calibration with APB access.
// Assumes: Zero-wait APB slave; input currents are on pclk, in microamperes.
// Notes: Parameter requests run in the cycle their request word is written.
//
// The APB register port and the register offsets were chosen for this implementation.
module current_input_calibration (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [3:0][15:0] input_current,
  input  wire logic [3:0]       sample_valid,
  output logic      [3:0][15:0] numerical_count,
  output logic      [3:0][7:0]  channel_status,
  output logic      [3:0]       count_valid
);
  // Configuration-only settings, one bit per channel.
  logic [3:0]       range_reg;
  logic [3:0]       fmt_reg;
  logic [3:0]       enable_reg;
  // Calibration parameters, one set per channel.
  logic [3:0][15:0] offset_reg;
  logic [3:0][15:0] max_reg;
  logic [3:0]       max_set_reg;
  logic [3:0][7:0]  avg_reg;
  logic [3:0][15:0] eff_max;
  // Parameter request mailbox.
  logic [15:0]      req_data_reg;
  logic [31:0]      request_reg;
  logic             resp_done_reg;
  logic             resp_err_reg;
  logic [15:0]      resp_data_reg;

  // APB access decode.
  wire        acc_phase    = psel & penable;
  wire        wr_acc       = acc_phase & pwrite;
  wire        sel_config   = paddr == calib_pkg::ADDR_CONFIG;
  wire        sel_request  = paddr == calib_pkg::ADDR_REQUEST;
  wire        sel_req_data = paddr == calib_pkg::ADDR_REQ_DATA;
  wire        sel_response = paddr == calib_pkg::ADDR_RESPONSE;
  wire        sel_rsp_data = paddr == calib_pkg::ADDR_RESP_DATA;
  wire        sel_result   = (paddr[7:4] == calib_pkg::ADDR_RESULT[7:4]) && (paddr[1:0] == 2'b00);
  wire [1:0]  res_ch       = paddr[3:2];
  wire        addr_mapped  = sel_config | sel_request | sel_req_data | sel_response
                           | sel_rsp_data | sel_result;

  // Fields of a parameter request word.
  wire        req_go     = wr_acc & sel_request;
  wire [7:0]  req_idx_lo = pwdata[calib_pkg::REQ_IDXLO_LSB +: 8];
  wire [7:0]  req_idx_hi = pwdata[calib_pkg::REQ_IDXHI_LSB +: 8];
  wire [7:0]  req_sub    = pwdata[calib_pkg::REQ_SUB_LSB +: 8];
  wire [3:0]  req_len    = pwdata[calib_pkg::REQ_LEN_LSB +: 4];
  wire        req_wr     = pwdata[calib_pkg::REQ_WR_BIT];
  wire [7:0]  sub_minus  = req_sub - calib_pkg::SUB_FIRST;
  wire [1:0]  req_ch     = sub_minus[1:0];

  // Only three parameter objects answer; range and format never do.
  wire        sub_ok   = (req_sub >= calib_pkg::SUB_FIRST) && (req_sub <= calib_pkg::SUB_LAST);
  wire        hi_ok    = req_idx_hi == calib_pkg::IDX_HI_PARAM;
  wire        kind_off = hi_ok & sub_ok & (req_idx_lo == calib_pkg::IDX_OFFSET)
                       & (req_len == calib_pkg::LEN_WORD);
  wire        kind_max = hi_ok & sub_ok & (req_idx_lo == calib_pkg::IDX_MAXCNT)
                       & (req_len == calib_pkg::LEN_WORD);
  wire        kind_avg = hi_ok & sub_ok & (req_idx_lo == calib_pkg::IDX_AVERAGE)
                       & (req_len == calib_pkg::LEN_BYTE);
  wire        req_known = kind_off | kind_max | kind_avg;

  // Data byte 1 is the low byte, data byte 2 the high byte.
  wire [15:0] req_value = req_data_reg;
  wire [7:0]  avg_value = req_data_reg[7:0];
  wire        sel_fmt   = fmt_reg[req_ch];

  // Limit checks against the format of the addressed channel.
  wire        off_s_ok = ($signed(req_value) >= $signed(calib_pkg::OFF_S_MIN))
                       && ($signed(req_value) <= $signed(calib_pkg::OFF_S_MAX));
  wire        off_u_ok = req_value <= calib_pkg::OFF_U_MAX;
  wire        max_s_ok = (req_value >= calib_pkg::MAX_S_MIN)
                       && (req_value <= calib_pkg::MAX_S_MAX);
  wire        max_u_ok = req_value >= calib_pkg::MAX_U_MIN;
  wire        off_ok   = sel_fmt ? off_u_ok : off_s_ok;
  wire        max_ok   = sel_fmt ? max_u_ok : max_s_ok;
  wire        avg_ok   = (avg_value >= calib_pkg::AVG_MIN) && (avg_value <= calib_pkg::AVG_MAX);
  wire        value_ok = (kind_off & off_ok) | (kind_max & max_ok) | (kind_avg & avg_ok);

  // Accept a write only when in range; other writes and unknown objects are flagged.
  wire        accept   = req_go & req_wr & value_ok;
  wire        reject   = req_go & (~req_known | (req_wr & ~value_ok));
  wire        read_ok  = req_go & ~req_wr & req_known;
  wire [15:0] rd_value = kind_off ? offset_reg[req_ch]
                       : kind_max ? eff_max[req_ch]
                       : {8'h00, avg_reg[req_ch]};

  // Full-scale count follows the format default until a value is written.
  genvar e;
  for (e = 0; e < calib_pkg::NUM_CH; e++) begin : g_eff
    assign eff_max[e] = max_set_reg[e] ? max_reg[e]
                      : (fmt_reg[e] ? calib_pkg::FS_U : calib_pkg::FS_S);
  end

  // Register read words.
  wire [31:0] cfg_word  = (32'(enable_reg) << calib_pkg::CFG_EN_LSB)
                        | (32'(fmt_reg) << calib_pkg::CFG_FMT_LSB)
                        | (32'(range_reg) << calib_pkg::CFG_RANGE_LSB);
  wire [31:0] resp_word = (32'(resp_err_reg) << calib_pkg::RESP_ERR_BIT)
                        | (32'(resp_done_reg) << calib_pkg::RESP_DONE_BIT);
  wire [31:0] res_word  = (32'(channel_status[res_ch]) << calib_pkg::RES_STATUS_LSB)
                        | 32'(numerical_count[res_ch]);

  // Read data selection; unmapped reads return zero with an error.
  assign prdata = sel_config   ? cfg_word
                : sel_request  ? request_reg
                : sel_req_data ? 32'(req_data_reg)
                : sel_response ? resp_word
                : sel_rsp_data ? 32'(resp_data_reg)
                : sel_result   ? res_word
                : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = acc_phase & ~addr_mapped;

  // Range, format and enable are written only through the config register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_reg  <= calib_pkg::CFG_RANGE_RESET;
      fmt_reg    <= calib_pkg::CFG_FMT_RESET;
      enable_reg <= calib_pkg::CFG_EN_RESET;
    end else if (wr_acc && sel_config) begin
      range_reg  <= pwdata[calib_pkg::CFG_RANGE_LSB +: 4];
      fmt_reg    <= pwdata[calib_pkg::CFG_FMT_LSB +: 4];
      enable_reg <= pwdata[calib_pkg::CFG_EN_LSB +: 4];
    end
  end

  // Mailbox data and the last request word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_data_reg <= 16'h0000;
      request_reg  <= 32'h0000_0000;
    end else begin
      if (wr_acc && sel_req_data) begin
        req_data_reg <= pwdata[15:0];
      end
      if (req_go) begin
        request_reg <= pwdata;
      end
    end
  end

  // Response flags: done is sticky until software writes a one to it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_done_reg <= 1'b0;
      resp_err_reg  <= 1'b0;
      resp_data_reg <= 16'h0000;
    end else begin
      if (req_go) begin
        resp_done_reg <= 1'b1;
        resp_err_reg  <= reject;
      end else if (wr_acc && sel_response && pwdata[calib_pkg::RESP_DONE_BIT]) begin
        resp_done_reg <= 1'b0;
      end
      if (read_ok) begin
        resp_data_reg <= rd_value;
      end
    end
  end

  // Per-channel parameter storage; only the addressed channel changes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_reg  <= {calib_pkg::NUM_CH{calib_pkg::OFF_RESET}};
      max_reg     <= {calib_pkg::NUM_CH{calib_pkg::FS_S}};
      max_set_reg <= 4'h0;
      avg_reg     <= {calib_pkg::NUM_CH{calib_pkg::AVG_RESET}};
    end else if (accept) begin
      if (kind_off) begin
        offset_reg[req_ch] <= req_value;
      end
      if (kind_max) begin
        max_reg[req_ch]     <= req_value;
        max_set_reg[req_ch] <= 1'b1;
      end
      if (kind_avg) begin
        avg_reg[req_ch] <= avg_value;
      end
    end
  end

  // One converter and one calibrator per channel, joined by the channel carrier.
  genvar g;
  for (g = 0; g < calib_pkg::NUM_CH; g++) begin : g_ch
    calib_chan_if chif ();
    assign chif.range_020    = range_reg[g];
    assign chif.fmt_unsigned = fmt_reg[g];
    assign chif.enable       = enable_reg[g];
    assign chif.offset       = offset_reg[g];
    assign chif.max_count    = eff_max[g];

    count_converter u_conv (
      .pclk          (pclk),
      .presetn       (presetn),
      .input_current (input_current[g]),
      .sample_valid  (sample_valid[g]),
      .ch            (chif.conv)
    );

    count_calibrator u_cal (
      .pclk    (pclk),
      .presetn (presetn),
      .ch      (chif.cal)
    );

    assign numerical_count[g] = chif.result;
    assign channel_status[g]  = chif.status;
    assign count_valid[g]     = chif.result_valid;
  end

  AST_RESET_CAL: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> offset_reg == '0 && max_set_reg == 4'h0 && enable_reg == 4'hf)
    else $error("Calibration values are not at their reset state.");
  AST_REJECT_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
    req_go && !accept |=> $stable(offset_reg) && $stable(max_reg) && $stable(avg_reg))
    else $error("A rejected or read request changed a stored parameter.");
  AST_OFF_STORED: assert property (@(posedge pclk) disable iff (!presetn)
    accept && kind_off |=> offset_reg[$past(req_ch)] == $past(req_value) && !resp_err_reg)
    else $error("Accepted offset write was not stored.");
  AST_OFF_S_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    req_go && req_wr && kind_off && !sel_fmt && req_value == 16'hfd00 |=> resp_err_reg)
    else $error("Signed offset below -767 was accepted.");
  AST_OFF_U_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    req_go && req_wr && kind_off && sel_fmt && req_value == 16'h0600 |=> resp_err_reg)
    else $error("Unsigned offset above 1535 was accepted.");
  AST_MAX_S_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    req_go && req_wr && kind_max && !sel_fmt && req_value == 16'h7a00 |=> resp_err_reg)
    else $error("Signed full-scale count below 31233 was accepted.");
  AST_MAX_U_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    req_go && req_wr && kind_max && sel_fmt && req_value == 16'hf400
      |=> resp_err_reg && $stable(max_reg))
    else $error("Unsigned full-scale count below 62465 was accepted.");
  AST_UNKNOWN_OBJ: assert property (@(posedge pclk) disable iff (!presetn)
    req_go && !req_known |=> resp_done_reg && resp_err_reg)
    else $error("Request to an unreachable object was not flagged.");

  // Signed offset upper limit; stored values land on the addressed channel, an offset write leaves the next channel alone, and range and format stay put.
  AST_OFF_S_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    req_go && req_wr && kind_off && !sel_fmt && req_value == 16'h0300 |=> resp_err_reg)
    else $error("Signed offset above +767 was accepted.");
  AST_MAX_STORED: assert property (@(posedge pclk) disable iff (!presetn)
    accept && kind_max |=> eff_max[$past(req_ch)] == $past(req_value))
    else $error("Accepted full-scale count was not stored.");
  AST_AVG_STORED: assert property (@(posedge pclk) disable iff (!presetn)
    accept && kind_avg |=> avg_reg[$past(req_ch)] == $past(avg_value))
    else $error("Accepted averaging depth was not stored.");
  AST_OTHER_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
    accept && kind_off |=> offset_reg[$past(req_ch) + 2'd1] == $past(offset_reg[req_ch + 2'd1]))
    else $error("An offset write changed another channel.");
  AST_CFG_UNTOUCHED: assert property (@(posedge pclk) disable iff (!presetn)
    req_go |=> $stable(range_reg) && $stable(fmt_reg) && resp_done_reg)
    else $error("A parameter request changed range or format.");
endmodule // current_input_calibration

// >>> tb/current_input_calibration_test.sv
// Purpose: Self-checking bench for the current input calibration block.
// Assumes: Currents in microamperes; requests go through the interface model.
// Notes: Refused writes are gathered in one table.
module current_input_calibration_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, q, r, d;
  logic [3:0][15:0] cur;
  logic [3:0]       sv, cv;
  logic [31:0]      bv [8] = '{32'h0200_0300, 32'h0400_0600, 32'h0201_7a00,
                               32'h0401_7fff, 32'h0103_0000, 32'h0500_0000,
                               32'h0200_fd00, 32'h0401_f400};
  int               n_fail, compares;
  current_input_calibration uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .input_current(cur), .sample_valid(sv),
    .numerical_count(), .channel_status(), .count_valid(cv));
  param_master network_interface_module (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // The clock has a 40 ns period.
  always #20 pclk = ~pclk;
  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Reads one channel result and compares its count.
  task automatic res(input logic [7:0] ch, input logic [15:0] e);
    network_interface_module.xfer(1'b0, 8'h20 + 8'(ch << 2), 32'h0, q);
    chk({16'h0000, q[15:0]}, {16'h0000, e});
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A bus wait that runs out counts as a mismatch and ends the run.
  always @(posedge network_interface_module.timed_out) begin
    n_fail++;
    results();
  end
  // Main sequence.
  initial begin
    {pclk, presetn, n_fail, compares} = '0;
    cur = {16'h0fa0, 16'h2ee0, 16'h0fc0, 16'h4e20};
    sv = 4'hf;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    network_interface_module.xfer(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h0000_0f00);
    res(0, 16'h7d00);
    res(1, 16'h0040);
    res(3, 16'h0000);
    network_interface_module.req(1'b0, 8'h01, 8'h02, 4'h2, 16'h0, r, d);
    chk(d, 32'h0000_7d00);
    cur[0] <= 16'h2710;
    cur[3] <= 16'h1388;
    network_interface_module.xfer(1'b1, 8'h00, 32'h0000_0fc9, q);
    res(0, 16'h3e80);
    res(2, 16'h7d00);
    res(3, 16'h3e80);
    network_interface_module.req(1'b1, 8'h00, 8'h02, 4'h2, 16'h0040, r, d);
    network_interface_module.req(1'b1, 8'h01, 8'h02, 4'h2, 16'h7c00, r, d);
    chk(r, 32'h0000_0001);
    res(1, 16'h0000);
    cur <= {16'h4e20, 16'h2ee0, 16'h4da0, 16'h61a8};
    foreach (bv[i]) begin
      network_interface_module.req(1'b1, bv[i][23:16], bv[i][31:24], 4'h2, bv[i][15:0], r, d);
      chk(r, 32'h0000_0003);
    end
    res(0, 16'h7fff);
    res(1, 16'h7d00);
    res(2, 16'h7d00);
    res(3, 16'hfa00);
    cur[1] <= 16'h5208;
    network_interface_module.req(1'b0, 8'h00, 8'h02, 4'h2, 16'h0, r, d);
    chk(d, 32'h0000_0040);
    network_interface_module.req(1'b1, 8'h02, 8'h04, 4'h1, 16'h0050, r, d);
    network_interface_module.req(1'b0, 8'h02, 8'h04, 4'h1, 16'h0, r, d);
    chk(d, 32'h0000_0050);
    network_interface_module.xfer(1'b0, 8'h24, 32'h0, q);
    chk(q, 32'h0002_7fff);
    sv <= 4'h5;
    network_interface_module.xfer(1'b1, 8'h00, 32'h0000_07c9, q);
    network_interface_module.xfer(1'b0, 8'h2c, 32'h0, q);
    chk(q, 32'h0000_0000);
    chk(32'(cv), 32'h0000_0005);
    network_interface_module.xfer(1'b0, 8'h40, 32'h0, q);
    chk({q[30:0], network_interface_module.err}, 32'h0000_0001);
    results();
  end
endmodule // current_input_calibration_test

// >>> tb/param_master.sv
// Purpose: Network interface model issuing APB transfers and parameter requests.
// Assumes: The block answers with pready; every wait is bounded.
// Notes: A wait that runs out raises timed_out, which ends the run as a failure.
module param_master (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic err;
  logic timed_out;
  // The bus is idle from time zero.
  initial {psel, penable, pwrite, paddr, pwdata, timed_out} = '0;
  // Setup, then access held until pready is sampled high, then release.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (int n = 0; n < 64 && pready !== 1'b1; n++) @(posedge pclk);
    q = (pready === 1'b1) ? prdata : 'x;
    if (pready !== 1'b1) begin
      timed_out <= 1'b1;
    end
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  // The data word goes first, then the request word, then the answer is read.
  task automatic req(input logic w, input logic [7:0] idx, sub, input logic [3:0] len,
                     input logic [15:0] v, output logic [31:0] rsp, dat);
    logic [31:0] x;
    xfer(1'b1, 8'h08, {16'h0000, v[15:8], v[7:0]}, x);
    xfer(1'b1, 8'h04, {3'b000, w, len, sub, 8'h24, idx}, x);
    xfer(1'b0, 8'h0c, 32'h0, rsp);
    xfer(1'b0, 8'h10, 32'h0, dat);
  endtask
endmodule // param_master
